// >>> sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic core_clk_i = 0, nrst_i = 0, enter_utility_i = 0, rx_valid_i = 0, reg_wr_i = 0;
	logic reg_rd_i = 0, tx_valid_o, tx_ready_i, rx_ready_o, utility_mode_o, fail_mode = 0;
	logic flash_save_req_o, done, fail;
	logic [7:0] rx_data_i = 0, tx_data_o, reg_addr_i = 0, unit;
	logic [31:0] reg_wdata_i = 0, reg_rdata_o, err_event_i = 0, errv;
	logic [23:0] filt;
	int bad_count = 0, n_checks = 0;
	string cmds[5] = '{"$iau,", "$iau,", "iau,", "$dbto,", "$iau,5,"};
	string exps[5] = '{"#iau,", "#,", "#,", "#,", "#iau,"};
	int bumps[5] = '{0, 1, 1, 0, 0};
	logic [3:0] sts[5] = '{4'h0, 4'h2, 4'h1, 4'h3, 4'h4};
	always #2 core_clk_i = ~core_clk_i;
	ucp_cmd_interp #(.ERR_BYTES(4)) u_ucp_cmd_interp (.core_clk_i(core_clk_i),
		.nrst_i(nrst_i), .enter_utility_i(enter_utility_i), .utility_mode_o(utility_mode_o),
		.rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o),
		.tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
		.flash_save_req_o(flash_save_req_o), .flash_save_done_i(done), .flash_save_fail_i(fail),
		.cfg_axis_o(), .cfg_acc_filt_o(), .cfg_acc_unit_o(), .err_event_i(err_event_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
	ucp_far_model u_ucp_far_model (.clk_i(core_clk_i), .nrst_i(nrst_i), .tx_valid_i(tx_valid_o),
		.tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i), .save_req_i(flash_save_req_o),
		.fail_mode_i(fail_mode), .done_o(done), .fail_o(fail));
	function automatic logic [7:0] crc8(string s);
		logic [7:0] c = 8'hFF;
		for (int i = 0; i < s.len(); i++)
		begin
			c ^= s[i];
			repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
		end
		return c;
	endfunction : crc8
	function automatic string seal(string s, int bump);
		return {s, $sformatf("%0d%c", crc8(s) + bump, 8'h0D)};
	endfunction : seal
	task automatic chk(string nm, string e, string g);
		n_checks++;
		if (e != g)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %s seen %s", nm, e, g);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [31:0] d);
		reg_wr_i <= 1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 0;
		@(posedge core_clk_i);
	endtask : wr
	task automatic rd(logic [7:0] a, logic [31:0] e);
		reg_rd_i <= 1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 0;
		@(negedge core_clk_i);
		chk($sformatf("reg %0h", a), $sformatf("%h", e), $sformatf("%h", reg_rdata_o));
		@(posedge core_clk_i);
	endtask : rd
	task automatic run(string s, int bump, string e);
		string ln = seal(s, bump);
		u_ucp_far_model.resp = "";
		for (int i = 0; i < ln.len(); i++)
		begin
			rx_valid_i <= 1;
			rx_data_i <= ln[i];
			do @(negedge core_clk_i); while (rx_ready_o !== 1'b1);
			@(posedge core_clk_i);
		end
		rx_valid_i <= 0;
		for (int i = 0; i < 3000 && !u_ucp_far_model.resp.len(); i++)
			@(posedge core_clk_i);
		for (int i = 0; i < 3000 &&
			u_ucp_far_model.resp[u_ucp_far_model.resp.len()-1] != 8'h0D; i++)
			@(posedge core_clk_i);
		chk(s, seal(e, 0), u_ucp_far_model.resp);
		$display("test %s done", s);
	endtask : run
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	initial
	begin
		// A few hundred cycles per command at most, with a wide margin
		#80000;
		bad_count++;
		print_verdict();
	end
	initial
	begin
		void'($urandom(37230));
		repeat (5) @(posedge core_clk_i);
		nrst_i <= 1;
		rd(8'h00, 32'h7);
		rd(8'h04, 32'h40404);
		rd(8'h08, 32'h1);
		rd(8'h0C, 32'h0);
		rd(8'h20, 32'h0);
		enter_utility_i <= 1;
		@(posedge core_clk_i);
		enter_utility_i <= 0;
		unit = 8'($urandom);
		filt = 24'($urandom);
		wr(8'h08, {24'h0, unit});
		wr(8'h04, {8'h0, filt});
		wr(8'h00, 32'h5);
		foreach (cmds[i])
		begin
			run(cmds[i], bumps[i], {exps[i], $sformatf("%0d,", sts[i]),
				(i == 0) ? $sformatf("%0d,", unit) : ""});
			rd(8'h10, {27'h0, 1'b1, sts[i]});
		end
		run("$iaf,", 0, $sformatf("#iaf,0,%0d,NA,%0d,", filt[7:0], filt[23:16]));
		errv = $urandom;
		err_event_i <= errv;
		@(posedge core_clk_i);
		err_event_i <= 0;
		run("$ie,", 0, $sformatf("#ie,0,%0d,%0d,%0d,%0d,", errv[31:24], errv[23:16],
			errv[15:8], errv[7:0]));
		run("$ie,", 0, "#ie,0,0,0,0,0,");
		run("$save,", 0, "#save,6,0,");
		wr(8'h0C, 32'h3);
		run("$save,", 0, "#save,0,2,");
		fail_mode <= 1;
		run("$save,", 0, "#save,7,2,");
		fail_mode <= 0;
		rd(8'h0C, 32'h2);
		run("$xn,", 0, "#xn,0,");
		@(negedge core_clk_i);
		chk("mode", "0", $sformatf("%b", utility_mode_o));
		// Reset in mid-run must drop every setting back to its default, even after a save
		@(posedge core_clk_i);
		nrst_i <= 0;
		repeat (5) @(posedge core_clk_i);
		nrst_i <= 1;
		rd(8'h00, 32'h7);
		rd(8'h04, 32'h40404);
		rd(8'h08, 32'h1);
		rd(8'h0C, 32'h0);
		$display("test reset defaults done");
		print_verdict();
	end
endmodule : testbench
`default_nettype wire

// >>> sim/ucp_far_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Response sink and flash stand-in
// ----------------------------------------
module ucp_far_model (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o,
	input wire logic save_req_i,
	input wire logic fail_mode_i,
	output logic done_o,
	output logic fail_o
);
	string resp;
	logic [2:0] cnt_ff;
	always @(posedge clk_i)
	begin
		// Stall now and then so held bytes are exercised
		tx_ready_o <= nrst_i && (($urandom % 4) != 0);
		if (tx_valid_i && tx_ready_o)
			resp = {resp, $sformatf("%c", tx_data_i)};
		// One-cycle answer pulse as the countdown runs out
		done_o <= nrst_i && !save_req_i && (cnt_ff == 3'h1) && !fail_mode_i;
		fail_o <= nrst_i && !save_req_i && (cnt_ff == 3'h1) && fail_mode_i;
		if (!nrst_i)
			cnt_ff <= 3'h0;
		else if (save_req_i)
			cnt_ff <= 3'h5;
		else if (cnt_ff != 3'h0)
			cnt_ff <= cnt_ff - 3'h1;
	end
endmodule : ucp_far_model
`default_nettype wire

// >>> src/ucp_cmd_interp.sv
`timescale 1ns/10ps
`default_nettype none
`include "ucp_params.svh"

// What this block does
// - Checksum is CRC-8, polynomial x^8+x^2+x+1, register seeded with all ones.
// - CRC covers every character from start character through the final comma.
// - Checksum field is the CRC byte written in decimal ASCII, 0 to 255.
// - Commands and responses both end with the checksum as last field.
// - Second response field is status; zero means decoded and executed cleanly.
// - Status one when dollar sign missing or the line runs past the maximum body length.
// - Status two when received checksum differs from computed CRC.
// - Status three when a started command names an unknown command.
// - Status four, name echoed, on wrong parameter count.
// - Statuses one to three leave the command field empty.
// - Status five, name echoed, when parameter values are unacceptable; no command here takes parameters, so five is never returned.
// - Save with none remaining still saves, returns six and zero remaining.
// - Failed save returns seven with the current remaining count.
// - Clamped bias trim change returns eight with resulting offsets; no command here trims bias, so eight is never returned.
// - Several errors report only the lowest status code.
// - Error query returns accumulated error bytes then clears the accumulator.
// - Save writes all configuration to flash; terminate returns to normal mode.
// - Filter query returns X, Y, Z codes, NA for unconfigured axes.
// - Unit query returns one unit code; one means incremental velocity.
// - Response starts with hash, then name, status, comma fields, CR.
// - Command changes are volatile until reset unless saved; here reset loads the defaults even after a save.
module ucp_cmd_interp #(
	parameter int ERR_BYTES = 16
)(
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic enter_utility_i,
	output logic utility_mode_o,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	output logic rx_ready_o,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	output logic flash_save_req_o,
	input wire logic flash_save_done_i,
	input wire logic flash_save_fail_i,
	output logic [2:0] cfg_axis_o,
	output logic [23:0] cfg_acc_filt_o,
	output logic [7:0] cfg_acc_unit_o,
	input wire logic [8*ERR_BYTES-1:0] err_event_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o
);
	import ucp_pkg::*;

	// ----------------------------------------
	// CRC step
	// ----------------------------------------
	function automatic logic [7:0] crc8_upd(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++)
		begin
			r = r[7] ? ({r[6:0], 1'b0} ^ `UCP_CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction : crc8_upd

	ucp_state_type state_ff, nxt_state;
	ucp_cmd_type cmd_ff, cmd_dec;
	logic mode_ff, dollar_ok_ff, too_long_ff, name_ovf_ff, chk_bad_ff, chk_dig_ff;
	logic [6:0] len_ff, comma_cnt_ff;
	logic [39:0] name_ff;
	logic [2:0] name_len_ff, ci_ff, pi_ff;
	logic [7:0] rxcrc_ff, commacrc_ff, txcrc_ff, out_data_ff, emit_chr;
	logic [8:0] chk_ff;
	logic [3:0] status_ff, st_sel, dig_ff;
	logic [15:0] saves_ff, rep_saves_ff, num_ff, pow, val_mux;
	logic [8*ERR_BYTES-1:0] acc_ff, snap_ff;
	logic [4:0] fi_ff, val_cnt, last_fi, val_idx;
	logic lead_ff, out_vld_ff, emit_vld;
	logic [2:0] axis_ff;
	logic [23:0] filt_ff;
	logic [7:0] unit_ff;
	logic [31:0] rdata_ff;

	// ----------------------------------------
	// Receive decode
	// ----------------------------------------
	wire rx_take = rx_valid_i && rx_ready_o;
	wire rx_is_cr = rx_data_i == `UCP_CH_CR;
	wire rx_is_comma = rx_data_i == `UCP_CH_COMMA;
	wire rx_is_ws = (rx_data_i == `UCP_CH_SP) || (rx_data_i == `UCP_CH_HT);
	wire rx_is_digit = (rx_data_i >= `UCP_CH_ZERO) && (rx_data_i <= `UCP_CH_NINE);
	wire [7:0] rx_crc_nxt = crc8_upd(rxcrc_ff, rx_data_i);
	wire [11:0] chk_x10 = {chk_ff, 3'h0} + {2'h0, chk_ff, 1'h0} + {8'h00, rx_data_i[3:0]};
	wire in_name = comma_cnt_ff == 7'h00;

	assign rx_ready_o = mode_ff && ((state_ff == S_IDLE) || (state_ff == S_RX));

	// ----------------------------------------
	// Command parse
	// ----------------------------------------
	// A command arriving while a response is in flight is refused by rx_ready_o.
	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
		begin
			dollar_ok_ff <= 1'b0;
			too_long_ff <= 1'b0;
			len_ff <= 7'h00;
			comma_cnt_ff <= 7'h00;
			name_ff <= 40'h00_0000_0000;
			name_len_ff <= 3'h0;
			name_ovf_ff <= 1'b0;
			rxcrc_ff <= `UCP_CRC_SEED;
			commacrc_ff <= `UCP_CRC_SEED;
			chk_ff <= 9'h000;
			chk_bad_ff <= 1'b0;
			chk_dig_ff <= 1'b0;
		end
		else if (rx_take && state_ff == S_IDLE)
		begin
			dollar_ok_ff <= rx_data_i == `UCP_CH_DOLLAR;
			too_long_ff <= 1'b0;
			len_ff <= 7'h01;
			comma_cnt_ff <= 7'h00;
			name_ff <= 40'h00_0000_0000;
			name_len_ff <= 3'h0;
			name_ovf_ff <= 1'b0;
			rxcrc_ff <= crc8_upd(`UCP_CRC_SEED, rx_data_i);
			chk_ff <= 9'h000;
			chk_bad_ff <= 1'b0;
			chk_dig_ff <= 1'b0;
		end
		else if (rx_take && !rx_is_cr)
		begin
			len_ff <= (len_ff == 7'h7F) ? len_ff : len_ff + 7'h01;
			too_long_ff <= too_long_ff || (len_ff >= `UCP_MAX_BODY);
			rxcrc_ff <= rx_crc_nxt;
			if (rx_is_comma)
			begin
				comma_cnt_ff <= (comma_cnt_ff == 7'h7F) ? comma_cnt_ff : comma_cnt_ff + 7'h01;
				commacrc_ff <= rx_crc_nxt;
				chk_ff <= 9'h000;
				chk_bad_ff <= 1'b0;
				chk_dig_ff <= 1'b0;
			end
			else if (in_name)
			begin
				if (name_len_ff == `UCP_NAME_MAX)
					name_ovf_ff <= 1'b1;
				else
				begin
					name_ff <= {name_ff[31:0], rx_data_i};
					name_len_ff <= name_len_ff + 3'h1;
				end
			end
			else if (rx_is_digit)
			begin
				chk_dig_ff <= 1'b1;
				if (chk_x10 > 12'h0FF)
					chk_bad_ff <= 1'b1;
				else
					chk_ff <= chk_x10[8:0];
			end
			else if (!(rx_is_ws && !chk_dig_ff))
				chk_bad_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// Status selection
	// ----------------------------------------
	assign cmd_dec = name_ovf_ff ? C_NONE :
		(name_ff == `UCP_NM_IAF) ? C_IAF :
		(name_ff == `UCP_NM_IAU) ? C_IAU :
		(name_ff == `UCP_NM_IE) ? C_IE :
		(name_ff == `UCP_NM_SAVE) ? C_SAVE :
		(name_ff == `UCP_NM_XN) ? C_XN : C_NONE;

	wire crc_bad = in_name || chk_bad_ff || !chk_dig_ff || (chk_ff != {1'b0, commacrc_ff});

	// Ascending chain so the lowest applicable code wins. None of the commands
	// here takes parameters or trims bias, so codes five and eight never arise.
	assign st_sel = (!dollar_ok_ff || too_long_ff) ? `UCP_ST_INVALID :
		crc_bad ? `UCP_ST_CRC :
		(cmd_dec == C_NONE) ? `UCP_ST_UNKNOWN :
		(comma_cnt_ff != 7'h01) ? `UCP_ST_NPARAM : `UCP_ST_OK;

	wire exec_ok = (state_ff == S_EXEC) && (st_sel == `UCP_ST_OK);
	wire err_clr = exec_ok && (cmd_dec == C_IE);

	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
		begin
			status_ff <= `UCP_ST_OK;
			cmd_ff <= C_NONE;
			rep_saves_ff <= 16'h0000;
		end
		else if (state_ff == S_EXEC)
		begin
			status_ff <= st_sel;
			cmd_ff <= cmd_dec;
		end
		else if (state_ff == S_SWAIT && flash_save_fail_i)
		begin
			status_ff <= `UCP_ST_SAVEERR;
			rep_saves_ff <= saves_ff;
		end
		else if (state_ff == S_SWAIT && flash_save_done_i)
		begin
			status_ff <= (saves_ff == 16'h0000) ? `UCP_ST_NOSAVES : `UCP_ST_OK;
			rep_saves_ff <= (saves_ff == 16'h0000) ? 16'h0000 : saves_ff - 16'h0001;
		end
	end

	// New events in the clearing cycle survive the clear.
	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
		begin
			acc_ff <= '0;
			snap_ff <= '0;
		end
		else
		begin
			acc_ff <= (err_clr ? '0 : acc_ff) | err_event_i;
			if (err_clr)
				snap_ff <= acc_ff;
		end
	end

	// ----------------------------------------
	// Response field values
	// ----------------------------------------
	wire has_vals = (status_ff == `UCP_ST_OK) ||
		((cmd_ff == C_SAVE) && (status_ff == `UCP_ST_NOSAVES || status_ff == `UCP_ST_SAVEERR));
	assign val_cnt = !has_vals ? 5'h00 :
		(cmd_ff == C_IAF) ? 5'h03 :
		(cmd_ff == C_IAU || cmd_ff == C_SAVE) ? 5'h01 :
		(cmd_ff == C_IE) ? 5'(ERR_BYTES) : 5'h00;
	assign last_fi = val_cnt + 5'h01;
	assign val_idx = fi_ff - 5'h01;
	wire echo = (status_ff == `UCP_ST_OK) || (status_ff >= `UCP_ST_NPARAM);
	wire name_more = echo && (ci_ff < name_len_ff);
	wire [7:0] name_chr = name_ff[8*(name_len_ff-ci_ff-3'h1) +: 8];
	wire load_na = (cmd_ff == C_IAF) && (fi_ff != 5'h00) && (fi_ff != last_fi) &&
		!axis_ff[val_idx[1:0]];

	assign val_mux = (fi_ff == 5'h00) ? {12'h000, status_ff} :
		(fi_ff == last_fi) ? {8'h00, txcrc_ff} :
		(cmd_ff == C_IAF) ? {8'h00, filt_ff[8*val_idx[1:0] +: 8]} :
		(cmd_ff == C_IAU) ? {8'h00, unit_ff} :
		(cmd_ff == C_IE) ? {8'h00, snap_ff[8*(ERR_BYTES-1-int'(val_idx)) +: 8]} :
		rep_saves_ff;

	assign pow = (pi_ff == 3'h0) ? `UCP_POW0 : (pi_ff == 3'h1) ? `UCP_POW1 :
		(pi_ff == 3'h2) ? `UCP_POW2 : (pi_ff == 3'h3) ? `UCP_POW3 : `UCP_POW4;
	wire num_ge = num_ff >= pow;
	wire dig_show = (dig_ff != 4'h0) || lead_ff || (pi_ff == `UCP_LAST_POW);
	wire can_emit = !out_vld_ff || tx_ready_i;
	wire fire = emit_vld && can_emit;
	wire step = !emit_vld || can_emit;
	wire crc_phase = !((state_ff == S_NUM) && (fi_ff == last_fi)) && (state_ff != S_CR);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb
	begin
		emit_vld = 1'b0;
		emit_chr = 8'h00;
		nxt_state = state_ff;
		unique case (state_ff)
			S_IDLE: if (rx_take) nxt_state = rx_is_cr ? S_EXEC : S_RX;
			S_RX: if (rx_take && rx_is_cr) nxt_state = S_EXEC;
			S_EXEC: nxt_state = (st_sel == `UCP_ST_OK && cmd_dec == C_SAVE) ? S_SREQ : S_HASH;
			S_SREQ: nxt_state = S_SWAIT;
			S_SWAIT: if (flash_save_fail_i || flash_save_done_i) nxt_state = S_HASH;
			S_HASH:
			begin
				emit_vld = 1'b1;
				emit_chr = `UCP_CH_HASH;
				if (can_emit) nxt_state = S_NAME;
			end
			S_NAME:
			begin
				emit_vld = name_more;
				emit_chr = name_chr;
				if (!name_more) nxt_state = S_SEP;
			end
			S_SEP:
			begin
				emit_vld = 1'b1;
				emit_chr = `UCP_CH_COMMA;
				if (can_emit) nxt_state = S_LOAD;
			end
			S_LOAD: nxt_state = load_na ? S_NA : S_NUM;
			S_NUM:
			begin
				emit_vld = !num_ge && dig_show;
				emit_chr = `UCP_CH_ZERO + {4'h0, dig_ff};
				if (!num_ge && step && pi_ff == `UCP_LAST_POW)
					nxt_state = (fi_ff == last_fi) ? S_CR : S_SEP;
			end
			S_NA:
			begin
				emit_vld = 1'b1;
				emit_chr = ci_ff[0] ? `UCP_CH_A : `UCP_CH_N;
				if (can_emit && ci_ff[0]) nxt_state = S_SEP;
			end
			S_CR:
			begin
				emit_vld = 1'b1;
				emit_chr = `UCP_CH_CR;
				if (can_emit) nxt_state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
			state_ff <= S_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
		begin
			fi_ff <= 5'h00;
			ci_ff <= 3'h0;
			pi_ff <= 3'h0;
			dig_ff <= 4'h0;
			lead_ff <= 1'b0;
			num_ff <= 16'h0000;
		end
		else if (state_ff == S_HASH || state_ff == S_LOAD)
		begin
			fi_ff <= (state_ff == S_HASH) ? 5'h00 : fi_ff;
			ci_ff <= 3'h0;
			pi_ff <= 3'h0;
			dig_ff <= 4'h0;
			lead_ff <= 1'b0;
			num_ff <= val_mux;
		end
		else if ((state_ff == S_NAME || state_ff == S_NA) && fire)
		begin
			ci_ff <= ci_ff + 3'h1;
			fi_ff <= (state_ff == S_NA && ci_ff[0]) ? fi_ff + 5'h01 : fi_ff;
		end
		else if (state_ff == S_NUM && num_ge)
		begin
			num_ff <= num_ff - pow;
			dig_ff <= dig_ff + 4'h1;
		end
		else if (state_ff == S_NUM && step)
		begin
			dig_ff <= 4'h0;
			lead_ff <= dig_show;
			pi_ff <= pi_ff + 3'h1;
			fi_ff <= (pi_ff == `UCP_LAST_POW) ? fi_ff + 5'h01 : fi_ff;
		end
	end

	// Checksum of the outgoing line, frozen once the checksum field starts.
	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
			txcrc_ff <= `UCP_CRC_SEED;
		else if (fire && crc_phase)
			txcrc_ff <= crc8_upd((state_ff == S_HASH) ? `UCP_CRC_SEED : txcrc_ff, emit_chr);
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
		begin
			out_vld_ff <= 1'b0;
			out_data_ff <= 8'h00;
		end
		else if (fire)
		begin
			out_vld_ff <= 1'b1;
			out_data_ff <= emit_chr;
		end
		else if (tx_ready_i)
			out_vld_ff <= 1'b0;
	end

	assign tx_valid_o = out_vld_ff;
	assign tx_data_o = out_data_ff;
	assign flash_save_req_o = state_ff == S_SREQ;

	// ----------------------------------------
	// Mode and registers
	// ----------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
			mode_ff <= 1'b0;
		else if (state_ff == S_CR && can_emit && cmd_ff == C_XN && status_ff == `UCP_ST_OK)
			mode_ff <= 1'b0;
		else if (enter_utility_i)
			mode_ff <= 1'b1;
	end

	wire wr_axis = reg_wr_i && reg_addr_i == `UCP_REG_AXIS;
	wire wr_filt = reg_wr_i && reg_addr_i == `UCP_REG_FILT;
	wire wr_unit = reg_wr_i && reg_addr_i == `UCP_REG_UNIT;
	wire wr_saves = reg_wr_i && reg_addr_i == `UCP_REG_SAVES;
	wire save_dec = state_ff == S_SWAIT && flash_save_done_i && !flash_save_fail_i &&
		saves_ff != 16'h0000;

	// Settings are volatile: reset restores defaults, even after a save.
	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
		begin
			axis_ff <= `UCP_RST_AXIS;
			filt_ff <= `UCP_RST_FILT;
			unit_ff <= `UCP_RST_UNIT;
			saves_ff <= `UCP_RST_SAVES;
		end
		else
		begin
			axis_ff <= wr_axis ? reg_wdata_i[2:0] : axis_ff;
			filt_ff <= wr_filt ? reg_wdata_i[23:0] : filt_ff;
			unit_ff <= wr_unit ? reg_wdata_i[7:0] : unit_ff;
			saves_ff <= wr_saves ? reg_wdata_i[15:0] : save_dec ? saves_ff - 16'h0001 : saves_ff;
		end
	end

	wire [31:0] rd_val = (reg_addr_i == `UCP_REG_AXIS) ? {29'h0000_0000, axis_ff} :
		(reg_addr_i == `UCP_REG_FILT) ? {8'h00, filt_ff} :
		(reg_addr_i == `UCP_REG_UNIT) ? {24'h00_0000, unit_ff} :
		(reg_addr_i == `UCP_REG_SAVES) ? {16'h0000, saves_ff} :
		(reg_addr_i == `UCP_REG_STAT) ?
		{26'h000_0000, state_ff != S_IDLE, mode_ff, status_ff} : 32'h0000_0000;

	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
			rdata_ff <= 32'h0000_0000;
		else
			rdata_ff <= reg_rd_i ? rd_val : 32'h0000_0000;
	end

	assign reg_rdata_o = rdata_ff;
	assign utility_mode_o = mode_ff;
	assign cfg_axis_o = axis_ff;
	assign cfg_acc_filt_o = filt_ff;
	assign cfg_acc_unit_o = unit_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_CRC_SEED: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(state_ff == S_HASH && can_emit) |=> txcrc_ff == crc8_upd(`UCP_CRC_SEED, `UCP_CH_HASH))
		else $error("tx checksum not seeded from all ones");
	AST_NUM_DIGIT: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(state_ff == S_NUM && fire) |=> (tx_data_o >= `UCP_CH_ZERO && tx_data_o <= `UCP_CH_NINE))
		else $error("number field emitted a non digit");
	AST_CRC_MISMATCH: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(state_ff == S_EXEC && dollar_ok_ff && !too_long_ff && !in_name && chk_dig_ff &&
		!chk_bad_ff && chk_ff[7:0] != commacrc_ff) |=> status_ff == `UCP_ST_CRC)
		else $error("checksum mismatch not reported as two");
	AST_NO_DOLLAR: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(state_ff == S_EXEC && !dollar_ok_ff) |=> (status_ff == `UCP_ST_INVALID && state_ff == S_HASH))
		else $error("missing start character not reported as one");
	AST_EMPTY_NAME: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(state_ff == S_NAME && status_ff >= `UCP_ST_INVALID && status_ff <= `UCP_ST_UNKNOWN)
		|-> !emit_vld ##1 state_ff == S_SEP)
		else $error("command field not empty on early failure");
	AST_SAVE_EXHAUSTED: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(state_ff == S_SWAIT && flash_save_done_i && !flash_save_fail_i && saves_ff == 16'h0000)
		|=> (status_ff == `UCP_ST_NOSAVES && rep_saves_ff == 16'h0000))
		else $error("exhausted save not reported as six with zero");
	AST_SAVE_FAIL: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(state_ff == S_SWAIT && flash_save_fail_i)
		|=> (status_ff == `UCP_ST_SAVEERR && rep_saves_ff == $past(saves_ff)))
		else $error("failed save not reported as seven with count");
	AST_ERR_CLEAR: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		err_clr |=> (snap_ff == $past(acc_ff) && acc_ff == $past(err_event_i)))
		else $error("error query did not snapshot and clear");
	AST_HASH_FIRST: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(state_ff == S_HASH && can_emit) |=> (tx_valid_o && tx_data_o == `UCP_CH_HASH))
		else $error("response does not open with hash");
	AST_SAVE_REQ: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(exec_ok && cmd_dec == C_SAVE) |=> flash_save_req_o ##1 !flash_save_req_o)
		else $error("save did not pulse the flash request once");
	AST_LEAVE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(state_ff == S_CR && can_emit && cmd_ff == C_XN && status_ff == `UCP_ST_OK)
		|=> !utility_mode_o)
		else $error("terminate did not leave utility mode");

endmodule : ucp_cmd_interp

`default_nettype wire

// >>> src/ucp_params.svh
`ifndef UCP_PARAMS_SVH
`define UCP_PARAMS_SVH

// ----------------------------------------
// Checksum
// ----------------------------------------
`define UCP_CRC_SEED 8'hFF
`define UCP_CRC_POLY 8'h07

// ----------------------------------------
// Characters
// ----------------------------------------
`define UCP_CH_DOLLAR 8'h24
`define UCP_CH_HASH 8'h23
`define UCP_CH_COMMA 8'h2C
`define UCP_CH_CR 8'h0D
`define UCP_CH_SP 8'h20
`define UCP_CH_HT 8'h09
`define UCP_CH_ZERO 8'h30
`define UCP_CH_NINE 8'h39
`define UCP_CH_N 8'h4E
`define UCP_CH_A 8'h41

// ----------------------------------------
// Command line limits and names (right aligned)
// ----------------------------------------
`define UCP_MAX_BODY 7'h63
`define UCP_NAME_MAX 3'h5
`define UCP_NM_IAF 40'h00_0069_6166
`define UCP_NM_IAU 40'h00_0069_6175
`define UCP_NM_IE 40'h00_0000_6965
`define UCP_NM_SAVE 40'h00_7361_7665
`define UCP_NM_XN 40'h00_0000_786E

// ----------------------------------------
// Status codes
// ----------------------------------------
`define UCP_ST_OK 4'h0
`define UCP_ST_INVALID 4'h1
`define UCP_ST_CRC 4'h2
`define UCP_ST_UNKNOWN 4'h3
`define UCP_ST_NPARAM 4'h4
`define UCP_ST_BADPARAM 4'h5
`define UCP_ST_NOSAVES 4'h6
`define UCP_ST_SAVEERR 4'h7
`define UCP_ST_TRIM 4'h8

// ----------------------------------------
// Decimal powers
// ----------------------------------------
`define UCP_POW0 16'h2710
`define UCP_POW1 16'h03E8
`define UCP_POW2 16'h0064
`define UCP_POW3 16'h000A
`define UCP_POW4 16'h0001
`define UCP_LAST_POW 3'h4

// ----------------------------------------
// Register map and reset values
// ----------------------------------------
`define UCP_REG_AXIS 8'h00
`define UCP_REG_FILT 8'h04
`define UCP_REG_UNIT 8'h08
`define UCP_REG_SAVES 8'h0C
`define UCP_REG_STAT 8'h10
`define UCP_RST_AXIS 3'h7
`define UCP_RST_FILT 24'h04_0404
`define UCP_RST_UNIT 8'h01
`define UCP_RST_SAVES 16'h0000

`endif

// >>> src/ucp_pkg.sv
package ucp_pkg;

	typedef enum logic [11:0]
	{
		S_IDLE = 12'b0000_0000_0001,
		S_RX = 12'b0000_0000_0010,
		S_EXEC = 12'b0000_0000_0100,
		S_SREQ = 12'b0000_0000_1000,
		S_SWAIT = 12'b0000_0001_0000,
		S_HASH = 12'b0000_0010_0000,
		S_NAME = 12'b0000_0100_0000,
		S_SEP = 12'b0000_1000_0000,
		S_LOAD = 12'b0001_0000_0000,
		S_NUM = 12'b0010_0000_0000,
		S_NA = 12'b0100_0000_0000,
		S_CR = 12'b1000_0000_0000
	} ucp_state_type;

	typedef enum logic [2:0]
	{
		C_NONE = 3'h0,
		C_IAF = 3'h1,
		C_IAU = 3'h2,
		C_IE = 3'h3,
		C_SAVE = 3'h4,
		C_XN = 3'h5
	} ucp_cmd_type;

endpackage : ucp_pkg
